/* File: hw/oadc_pkg.sv */
// package: constants, types and helpers of the oscillator and converter control
package oadc_pkg;

  // ---------------------------------------------------------------------
  // control word layout
  // ---------------------------------------------------------------------
  localparam int unsigned CTRL_BITS = 146;
  localparam int unsigned KEEP_BITS = 74;
  localparam int unsigned OSC_EN_POS = 65;
  localparam int unsigned BUF_SEL_POS = 64;
  localparam int unsigned GAIN1_LSB = 38;
  localparam int unsigned GAIN2_LSB = 66;
  localparam int unsigned OFFS1_LSB = 24;
  localparam int unsigned OFFS2_LSB = 52;
  localparam int unsigned GAIN_W = 8;
  localparam int unsigned OFFS_W = 7;

  // ---------------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------------
  localparam logic [7:0] GAIN_MID = 8'h3a;
  localparam logic [6:0] OFFS_MID = 7'h40;
  localparam logic RST_OSC_EN = 1'b1;
  localparam logic RST_BUF_SEL = 1'b0;
  localparam logic RST_ACCEPT = 1'b1;

  // ---------------------------------------------------------------------
  // register map (byte addresses) and field positions
  // ---------------------------------------------------------------------
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_GAIN = 8'h08;
  localparam logic [7:0] ADDR_OFFS = 8'h0c;
  localparam logic [7:0] ADDR_GTRIM = 8'h10;
  localparam logic [7:0] ADDR_OTRIM = 8'h14;
  localparam int unsigned CTRL_ACCEPT_POS = 0;
  localparam int unsigned STAT_OSC_POS = 0;
  localparam int unsigned STAT_BUF_POS = 1;
  localparam int unsigned STAT_LEN_ERR_POS = 2;
  localparam int unsigned STAT_DROP_POS = 3;
  localparam int unsigned STAT_BUSY_POS = 4;
  localparam int unsigned STAT_CNT_LSB = 8;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic osc_en;
    logic buf_sel;
    logic [GAIN_W-1:0] gain1;
    logic [OFFS_W-1:0] offs1;
    logic [GAIN_W-1:0] gain2;
    logic [OFFS_W-1:0] offs2;
  } oadc_set_t;

  typedef struct packed {
    logic [8:0] gain1_step;
    logic [8:0] gain2_step;
    logic [7:0] offs1_trim;
    logic [7:0] offs2_trim;
  } oadc_trim_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } oadc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } oadc_apb_rsp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_APPLY} oadc_cap_t;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // signed steps above the near-unity code; grows with the code
  function automatic logic [8:0] oadc_gain_step(input logic [7:0] code);
    oadc_gain_step = {1'b0, code} - {1'b0, GAIN_MID};
  endfunction : oadc_gain_step

  // signed steps of offset; falls as the code rises, zero near mid code
  function automatic logic [7:0] oadc_offs_trim(input logic [6:0] code);
    oadc_offs_trim = {1'b0, OFFS_MID} - {1'b0, code};
  endfunction : oadc_offs_trim

  function automatic oadc_set_t oadc_decode(
    input logic [KEEP_BITS-1:0] w
  );
    oadc_decode.osc_en = w[OSC_EN_POS];
    oadc_decode.buf_sel = w[BUF_SEL_POS];
    oadc_decode.gain1 = w[GAIN1_LSB +: GAIN_W];
    oadc_decode.gain2 = w[GAIN2_LSB +: GAIN_W];
    oadc_decode.offs1 = w[OFFS1_LSB +: OFFS_W];
    oadc_decode.offs2 = w[OFFS2_LSB +: OFFS_W];
  endfunction : oadc_decode

endpackage : oadc_pkg

/* File: hw/oadc_sync.sv */
// two-flop level synchroniser into the core clock
`timescale 1ns/1ps
`default_nettype none
module oadc_sync #(
  parameter int unsigned W = 1
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  initial begin
    if (W < 1) $error("oadc_sync: width must be at least one");
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (i_clk_en) begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule : oadc_sync
`default_nettype wire

/* File: hw/oadc_link.sv */
// link-clock side: shifts the control word in while the frame is open
`timescale 1ns/1ps
`default_nettype none
module oadc_link
  import oadc_pkg::*;
#(
  parameter int unsigned BITS = CTRL_BITS
) (
  // link pins
  input wire logic i_link_clk,
  input wire logic i_frame_en,
  input wire logic i_data,
  // captured word, stable while the frame is closed
  output logic [KEEP_BITS-1:0] o_word,
  output logic o_len_ok
);
  localparam logic [7:0] LAST = 8'(BITS - 1);
  logic [7:0] cnt_q;
  logic [KEEP_BITS-1:0] word_q;
  logic len_ok_q;

  initial begin
    if (BITS < KEEP_BITS || BITS > 254)
      $error("oadc_link: word length out of range");
  end

  // cleared while the frame is closed: the link clock may stand still
  always_ff @(posedge i_link_clk or negedge i_frame_en) begin
    if (!i_frame_en) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // highest bit first, so bit 0 of the word lands in bit 0 here
  always_ff @(posedge i_link_clk) begin
    if (i_frame_en) begin
      word_q <= {word_q[KEEP_BITS-2:0], i_data};
      len_ok_q <= (cnt_q == LAST);
    end
  end

  assign o_word = word_q;
  assign o_len_ok = len_ok_q;
endmodule : oadc_link
`default_nettype wire

/* File: hw/oadc_top.sv */
// oscillator mode and alignment converter control with apb status access
//
// Overview of operation
// - oscillator enable clear stops the oscillator, makes the buffer pin an input, hands the am loop-filter pin to the converters and ignores buffer select.
// - oscillator enable set runs the oscillator with the am loop-filter pin in its standard role.
// - with the oscillator on, buffer select 0 turns the buffer off and 1 makes it drive out.
// - first converter gain is the 8-bit code in word bits 38 to 45, bit 38 lowest.
// - second converter gain is the 8-bit code in word bits 66 to 73, bit 66 lowest.
// - gain rises in equal steps from code 0 at minimum to code 255 at maximum.
// - first converter offset is the 7-bit code in word bits 24 to 30, bit 24 lowest.
// - second converter offset is the 7-bit code in word bits 52 to 58, bit 52 lowest.
// - offset falls in equal steps from code 0 most positive to code 127 most negative.
// - offset code 64 is the near-zero offset and gain code 58 the near-unity gain.
//
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module oadc_top
  import oadc_pkg::*;
#(
  parameter int unsigned WORD_BITS = CTRL_BITS
) (
  // core clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // serial control link
  input wire logic i_link_clk,
  input wire logic i_link_en,
  input wire logic i_link_data,
  // apb slave
  input wire oadc_apb_req_t i_apb,
  output oadc_apb_rsp_t o_apb,
  // applied settings
  output oadc_set_t o_set,
  output oadc_trim_t o_trim,
  // pin modes
  output logic o_osc_run,
  output logic o_buf_drive,
  output logic o_buf_input,
  output logic o_am_loop_filter_pin_ext
);

  initial begin
    if (WORD_BITS < KEEP_BITS || WORD_BITS > 254)
      $error("oadc_top: word length out of range");
  end

  // -----------------------------------------------------------------------
  // link domain and crossing
  // -----------------------------------------------------------------------
  logic [KEEP_BITS-1:0] link_word;
  logic link_len_ok;
  logic en_sync;

  oadc_link #(
    .BITS(WORD_BITS)
  ) u_link (
    .i_link_clk(i_link_clk),
    .i_frame_en(i_link_en),
    .i_data(i_link_data),
    .o_word(link_word),
    .o_len_ok(link_len_ok)
  );

  // word and length flag are only read once the frame has closed, when
  // the link side holds them still; enable alone needs synchronising
  oadc_sync #(
    .W(1)
  ) u_en_sync (
    .i_clk(i_core_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_async(i_link_en),
    .o_sync(en_sync)
  );

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  oadc_cap_t cap_q;
  oadc_cap_t cap_d;
  oadc_set_t set_q;
  oadc_trim_t trim_q;
  oadc_apb_rsp_t rsp_q;
  logic accept_q;
  logic len_err_q;
  logic drop_q;
  logic [7:0] frame_cnt_q;
  logic osc_run_q;
  logic buf_drive_q;
  logic buf_input_q;
  logic am_loop_filter_pin_ext_q;

  // -----------------------------------------------------------------------
  // frame capture sequence
  // -----------------------------------------------------------------------
  wire cap_apply = (cap_q == ST_APPLY);
  wire take_ok = cap_apply & link_len_ok & accept_q;
  wire take_bad = cap_apply & ~link_len_ok;
  wire take_drop = cap_apply & link_len_ok & ~accept_q;
  wire oadc_set_t word_set = oadc_decode(link_word);

  always_comb begin
    cap_d = cap_q;
    case (cap_q)
      ST_IDLE: begin
        if (en_sync) cap_d = ST_FRAME;
      end
      ST_FRAME: begin
        if (!en_sync) cap_d = ST_APPLY;
      end
      ST_APPLY: begin
        cap_d = ST_IDLE;
      end
      default: begin
        cap_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cap_q <= ST_IDLE;
    end else if (i_clk_en) begin
      cap_q <= cap_d;
    end
  end

  // -----------------------------------------------------------------------
  // applied settings
  // -----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      set_q.osc_en <= RST_OSC_EN;
      set_q.buf_sel <= RST_BUF_SEL;
      set_q.gain1 <= GAIN_MID;
      set_q.gain2 <= GAIN_MID;
      set_q.offs1 <= OFFS_MID;
      set_q.offs2 <= OFFS_MID;
    end else if (i_clk_en && take_ok) begin
      set_q <= word_set;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      frame_cnt_q <= 8'h00;
    end else if (i_clk_en && take_ok) begin
      frame_cnt_q <= frame_cnt_q + 8'h01;
    end
  end

  // -----------------------------------------------------------------------
  // pin modes and converter codes
  // -----------------------------------------------------------------------
  wire osc_on = set_q.osc_en;
  wire buf_drive_d = osc_on & set_q.buf_sel;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      osc_run_q <= 1'b0;
      am_loop_filter_pin_ext_q <= 1'b0;
      buf_input_q <= 1'b0;
      buf_drive_q <= 1'b0;
    end else if (i_clk_en) begin
      osc_run_q <= osc_on;
      am_loop_filter_pin_ext_q <= ~osc_on;
      buf_input_q <= ~osc_on;
      buf_drive_q <= buf_drive_d;
    end
  end

  // linear codes: one code step is one analog step of the converter
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      trim_q <= '0;
    end else if (i_clk_en) begin
      trim_q.gain1_step <= oadc_gain_step(set_q.gain1);
      trim_q.gain2_step <= oadc_gain_step(set_q.gain2);
      trim_q.offs1_trim <= oadc_offs_trim(set_q.offs1);
      trim_q.offs2_trim <= oadc_offs_trim(set_q.offs2);
    end
  end

  // -----------------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------------
  wire apb_acc = i_apb.psel & i_apb.penable;
  wire apb_first = apb_acc & ~rsp_q.pready;
  wire apb_done = apb_acc & rsp_q.pready;
  wire apb_wr = apb_done & i_apb.pwrite;
  wire hit_ctrl = (i_apb.paddr == ADDR_CTRL);
  wire hit_stat = (i_apb.paddr == ADDR_STAT);
  wire hit_gain = (i_apb.paddr == ADDR_GAIN);
  wire hit_offs = (i_apb.paddr == ADDR_OFFS);
  wire hit_gtrim = (i_apb.paddr == ADDR_GTRIM);
  wire hit_otrim = (i_apb.paddr == ADDR_OTRIM);
  wire hit_any = hit_ctrl | hit_stat | hit_gain | hit_offs | hit_gtrim
                 | hit_otrim;
  wire wr_ctrl = apb_wr & hit_ctrl;
  wire wr_stat = apb_wr & hit_stat;

  // -----------------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------------
  logic [31:0] rd_ctrl;
  logic [31:0] rd_stat;
  logic [31:0] rd_gain;
  logic [31:0] rd_offs;
  logic [31:0] rd_gtrim;
  logic [31:0] rd_otrim;
  logic [31:0] rd_data;

  assign rd_ctrl = {31'h0, accept_q};
  assign rd_stat = {16'h0, frame_cnt_q, 3'h0, en_sync, drop_q, len_err_q,
                    set_q.buf_sel, set_q.osc_en};
  assign rd_gain = {16'h0, set_q.gain2, set_q.gain1};
  assign rd_offs = {17'h0, set_q.offs2, 1'b0, set_q.offs1};
  assign rd_gtrim = {7'h0, trim_q.gain2_step, 7'h0, trim_q.gain1_step};
  assign rd_otrim = {16'h0, trim_q.offs2_trim, trim_q.offs1_trim};
  assign rd_data = ({32{hit_ctrl}} & rd_ctrl)
                 | ({32{hit_stat}} & rd_stat)
                 | ({32{hit_gain}} & rd_gain)
                 | ({32{hit_offs}} & rd_offs)
                 | ({32{hit_gtrim}} & rd_gtrim)
                 | ({32{hit_otrim}} & rd_otrim);

  // -----------------------------------------------------------------------
  // apb response: one wait state so that every output is a flop
  // -----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rsp_q <= '0;
    end else if (i_clk_en) begin
      rsp_q.pready <= apb_first;
      rsp_q.pslverr <= apb_first & ~hit_any;
      rsp_q.prdata <= (apb_first && !i_apb.pwrite) ? rd_data : 32'h0;
    end
  end

  // -----------------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      accept_q <= RST_ACCEPT;
    end else if (i_clk_en && wr_ctrl) begin
      accept_q <= i_apb.pwdata[CTRL_ACCEPT_POS];
    end
  end

  // sticky flags: a frame outcome in the clearing cycle wins over the clear
  wire len_err_clr = wr_stat & i_apb.pwdata[STAT_LEN_ERR_POS];
  wire drop_clr = wr_stat & i_apb.pwdata[STAT_DROP_POS];

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      len_err_q <= 1'b0;
      drop_q <= 1'b0;
    end else if (i_clk_en) begin
      len_err_q <= take_bad | (len_err_q & ~len_err_clr);
      drop_q <= take_drop | (drop_q & ~drop_clr);
    end
  end

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  assign o_apb = rsp_q;
  assign o_set = set_q;
  assign o_trim = trim_q;
  assign o_osc_run = osc_run_q;
  assign o_buf_drive = buf_drive_q;
  assign o_buf_input = buf_input_q;
  assign o_am_loop_filter_pin_ext = am_loop_filter_pin_ext_q;

endmodule : oadc_top
`default_nettype wire

/* File: verification/oadc_top_asserts.sv */
// checker: port-level properties of the oscillator and converter control
`timescale 1ns/1ps
`default_nettype none
module oadc_top_asserts
  import oadc_pkg::*;
#(
  parameter int unsigned WORD_BITS = CTRL_BITS
) (
  // core clock and link enable
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_link_en,
  // apb and applied settings
  input wire oadc_apb_req_t i_apb,
  input wire oadc_apb_rsp_t o_apb,
  input wire oadc_set_t o_set,
  input wire oadc_trim_t o_trim,
  input wire logic o_osc_run,
  input wire logic o_buf_drive,
  input wire logic o_buf_input,
  input wire logic o_am_loop_filter_pin_ext
);
  // ---------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  a_osc_run_mode: assert property (i_clk_en |=>
    o_osc_run == $past(o_set.osc_en)) else $error("osc run wrong");
  a_buf_input_mode: assert property (i_clk_en |=>
    o_buf_input == !$past(o_set.osc_en) && o_am_loop_filter_pin_ext == !$past(o_set.osc_en))
    else $error("buffer input or loop pin mode wrong");
  a_buf_drive_mode: assert property (i_clk_en |=>
    o_buf_drive == ($past(o_set.osc_en) && $past(o_set.buf_sel)))
    else $error("buffer drive wrong");
  a_gain_step_value: assert property (i_clk_en |=>
    o_trim.gain1_step == {1'b0, $past(o_set.gain1)} - 9'h03a &&
    o_trim.gain2_step == {1'b0, $past(o_set.gain2)} - 9'h03a)
    else $error("gain step wrong");
  a_offs_trim_value: assert property (i_clk_en |=>
    o_trim.offs1_trim == 8'h40 - {1'b0, $past(o_set.offs1)} &&
    o_trim.offs2_trim == 8'h40 - {1'b0, $past(o_set.offs2)})
    else $error("offset trim wrong");
  // settings may only move once the frame has been closed for a while
  a_set_after_frame: assert property (!$stable(o_set) |->
    !$past(i_link_en) && !$past(i_link_en, 2) && !$past(i_link_en, 3))
    else $error("settings changed inside a frame");
  a_apb_one_wait: assert property ((i_clk_en && i_apb.psel && !i_apb.penable)
    ##1 (i_apb.psel && i_apb.penable) |-> !o_apb.pready ##1 o_apb.pready)
    else $error("apb answer not after one wait state");
  a_ready_one_cycle: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("pready longer than one cycle");
  a_freeze_holds: assert property (!i_clk_en |=>
    $stable(o_set) && $stable(o_apb))
    else $error("state moved while clock enable low");
  a_err_zero_data: assert property (o_apb.pslverr |->
    o_apb.pready && o_apb.prdata == 32'h0)
    else $error("error answer malformed");
endmodule : oadc_top_asserts
`default_nettype wire

/* File: verification/oadc_host_model.sv */
// host model: drives frames on the three-wire control link
`timescale 1ns/1ps
`default_nettype none
module oadc_host_model (
  // link pins
  output logic o_link_clk,
  output logic o_link_en,
  output logic o_link_data
);
  initial begin
    o_link_clk = 1'b0;
    o_link_en = 1'b0;
    o_link_data = 1'b0;
  end

  // sends the n lowest bits of w, highest first; clock runs in frames only
  task automatic send(input logic [145:0] w, input int n, input int slow);
    int i;
    #7;
    o_link_en = 1'b1;
    for (i = n - 1; i >= 0; i--) begin
      o_link_data = w[i];
      #(16 + slow);
      o_link_clk = 1'b1;
      #16;
      o_link_clk = 1'b0;
    end
    o_link_en = 1'b0;
    // no pull on the data line, so show the inverse once released
    o_link_data = ~o_link_data;
  endtask : send
endmodule : oadc_host_model
`default_nettype wire

/* File: verification/oadc_top_tb.sv */
// testbench: apb and link stimulus with self-checks for oadc_top
`timescale 1ns/1ps
`default_nettype none
module oadc_top_tb;
  import oadc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  wire link_clk;
  wire link_en;
  wire link_data;
  oadc_apb_req_t req = '0;
  oadc_apb_rsp_t rsp;
  oadc_set_t set;
  oadc_trim_t trim;
  logic osc_run, buf_drive, buf_input, am_loop_filter_pin_ext, err;
  logic [31:0] rd;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  int i;
  oadc_set_t tbl[3] = '{'{1'h1, 1'h1, 8'hff, 7'h00, 8'h00, 7'h7f},
                        '{1'h0, 1'h1, 8'h01, 7'h7f, 8'hfe, 7'h01},
                        '{1'h1, 1'h0, 8'h80, 7'h3f, 8'h3b, 7'h41}};

  always #12.5 clk = ~clk;

  oadc_host_model host (.o_link_clk(link_clk), .o_link_en(link_en),
    .o_link_data(link_data));
  oadc_top #(.WORD_BITS(146)) DUT (.i_core_clk(clk), .i_reset(rst),
    .i_clk_en(clk_en), .i_link_clk(link_clk), .i_link_en(link_en),
    .i_link_data(link_data), .i_apb(req), .o_apb(rsp), .o_set(set),
    .o_trim(trim), .o_osc_run(osc_run), .o_buf_drive(buf_drive),
    .o_buf_input(buf_input), .o_am_loop_filter_pin_ext(am_loop_filter_pin_ext));

  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task print_verdict;
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // wait for pready with no assumed latency; the watchdog ends a hang
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  // unused bits are set to ones so that a field leaking a neighbour shows
  function automatic logic [145:0] mkword(input oadc_set_t s);
    logic [145:0] w;
    w = '1;
    w[65] = s.osc_en;
    w[64] = s.buf_sel;
    w[45:38] = s.gain1;
    w[73:66] = s.gain2;
    w[30:24] = s.offs1;
    w[58:52] = s.offs2;
    return w;
  endfunction : mkword

  task frame(input oadc_set_t s, input int n, input int slow);
    host.send(mkword(s), n, slow);
    repeat (8) @(posedge clk);
  endtask : frame

  task check_set(input oadc_set_t s);
    chk(set, s);
    chk(osc_run, s.osc_en);
    chk(buf_input, !s.osc_en);
    chk(am_loop_filter_pin_ext, !s.osc_en);
    chk(buf_drive, s.osc_en & s.buf_sel);
    chk(trim.gain1_step, 9'({1'b0, s.gain1} - 9'h03a));
    chk(trim.offs2_trim, 8'(8'h40 - {1'b0, s.offs2}));
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, {16'h0, s.gain2, s.gain1});
    apb(1'b0, 8'h10, 32'h0);
    chk(rd[24:16], 9'({1'b0, s.gain2} - 9'h03a));
    apb(1'b0, 8'h14, 32'h0);
    chk(rd[7:0], 8'(8'h40 - {1'b0, s.offs1}));
  endtask : check_set

  // ---------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches++;
      print_verdict;
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check_set('{1'h1, 1'h0, 8'h3a, 7'h40, 8'h3a, 7'h40});
    for (i = 0; i < 3; i++) begin
      frame(tbl[i], 146, i * 40);
      check_set(tbl[i]);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[15:8], 8'h03);
    // one bit short: nothing may be applied
    frame(tbl[0], 145, 0);
    check_set(tbl[2]);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[2], 1'b0);
    // accept off drops a complete frame
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd[0], 1'b0);
    frame(tbl[0], 146, 0);
    check_set(tbl[2]);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[3], 1'b1);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h08, 32'hffff);
    check_set(tbl[2]);
    // core frozen: the frame is never seen and nothing moves
    clk_en <= 1'b0;
    frame(tbl[0], 146, 0);
    clk_en <= 1'b1;
    repeat (8) @(posedge clk);
    check_set(tbl[2]);
    apb(1'b0, 8'h18, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    print_verdict;
  end
endmodule : oadc_top_tb

bind oadc_top oadc_top_asserts #(.WORD_BITS(WORD_BITS)) u_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
  .i_link_en(i_link_en), .i_apb(i_apb), .o_apb(o_apb), .o_set(o_set),
  .o_trim(o_trim), .o_osc_run(o_osc_run), .o_buf_drive(o_buf_drive),
  .o_buf_input(o_buf_input), .o_am_loop_filter_pin_ext(o_am_loop_filter_pin_ext));
`default_nettype wire
